// *** mtm_regs.sv ***
// Modem mode, tone select and data registers with data engine
`timescale 1ns/1ps
module mtm_regs import mtm_pkg::*; #(
    parameter int BIT_CYCLES = CLK_HZ / BAUD_HZ
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic bus_sclk,
    input wire logic bus_cs_n,
    input wire logic bus_cmd_in,
    output logic bus_reply_out,
    output logic bus_reply_oe,
    input wire logic rx_line_bit,
    output logic tx_line_bit,
    output mtm_tone_t tx_tone,
    output logic [3:0] tx_mode,
    output logic [3:0] rx_mode,
    output logic [6:0] rx_atten_tenth_db,
    output logic rx_usart_on,
    output logic rx_sync,
    output logic [3:0] rx_char_bits,
    output logic rx_parity_en,
    output logic [2:0] rx_detector
);
    localparam int CW = $clog2(BIT_CYCLES + 1);
    localparam logic [CW-1:0] BIT_LAST = CW'(BIT_CYCLES - 1);
    localparam logic [CW-1:0] BIT_HALF = CW'(BIT_CYCLES / 2);

    initial begin
        if (BIT_CYCLES < 4) begin
            $error("BIT_CYCLES too small");
        end
    end

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} mtm_rx_state_t;

    mtm_wr_t wr;
    mtm_view_t view_reg, view_next;
    logic wr_tgl, rd_tgl;
    logic wr_s1, wr_s2, wr_s3, rd_s1, rd_s2, rd_s3;
    logic cs_s1, cs_s2, line_s1, line_s2;
    logic wr_evt, rd_evt, gen_cmd, clr;
    logic [15:0] ctrl_reg, ctrl_next, txm_reg, txm_next, rxm_reg, rxm_next;
    logic [7:0] txb_reg, txb_next, rxb_reg, rxb_next;
    logic tx_full_reg, tx_full_next, rx_rdy_reg, rx_rdy_next;
    logic [CW-1:0] ttick_reg, ttick_next, rtim_reg, rtim_next;
    logic [11:0] tsh_reg, tsh_next, frame;
    logic [3:0] tcnt_reg, tcnt_next, flen, nd, rnd, rtot;
    logic tline_next, par, tsync, tmodem;
    mtm_rx_state_t rst_reg, rst_next;
    logic [3:0] ridx_reg, ridx_next;
    logic [7:0] rsh_reg, rsh_next;
    logic rx_done, rx_on, rsync;
    mtm_tone_t tone_next;
    logic [6:0] atten_next;

    mtm_serial_slave u_slave (
        .sys_rst(sys_rst),
        .sclk(bus_sclk),
        .cs_n(bus_cs_n),
        .cmd_in(bus_cmd_in),
        .view(view_reg),
        .reply_out(bus_reply_out),
        .reply_oe(bus_reply_oe),
        .wr(wr),
        .wr_tgl(wr_tgl),
        .rd_tgl(rd_tgl)
    );

    // Crossings from bus clock and line pin
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            {wr_s1, wr_s2, wr_s3, rd_s1, rd_s2, rd_s3} <= 6'h00;
            {cs_s1, cs_s2, line_s1, line_s2} <= 4'hf;
        end else begin
            {wr_s1, wr_s2, wr_s3} <= {wr_tgl, wr_s1, wr_s2};
            {rd_s1, rd_s2, rd_s3} <= {rd_tgl, rd_s1, rd_s2};
            {cs_s1, cs_s2} <= {bus_cs_n, cs_s1};
            {line_s1, line_s2} <= {rx_line_bit, line_s1};
        end
    end

    // Register writes, reset conditions and ready flags
    always_comb begin
        wr_evt = wr_s2 ^ wr_s3;
        rd_evt = rd_s2 ^ rd_s3;
        gen_cmd = wr_evt && wr.addr == ADDR_GEN_RESET;
        clr = gen_cmd || ctrl_reg[CTRL_RESET_BIT];
        ctrl_next = ctrl_reg;
        txm_next = txm_reg;
        rxm_next = rxm_reg;
        txb_next = txb_reg;
        tx_full_next = tx_full_reg;
        if (wr_evt && wr.addr == ADDR_GEN_CTRL) begin
            ctrl_next = wr.data;
        end
        if (wr_evt && wr.addr == ADDR_TX_MODE) begin
            txm_next = wr.data;
        end
        if (wr_evt && wr.addr == ADDR_RX_MODE) begin
            rxm_next = wr.data;
        end
        if (tcnt_reg == 4'h0 && ttick_reg == CW'(0) && tx_full_reg) begin
            tx_full_next = 1'b0;
        end
        if (wr_evt && wr.addr == ADDR_TX_BYTE) begin
            txb_next = wr.data[7:0];
            tx_full_next = 1'b1; // RULE19
        end
        // Read clears, a new character in the same cycle wins
        rx_rdy_next = (rx_rdy_reg && !rd_evt) || rx_done; // RULE20
        rxb_next = rx_done ? rsh_next : rxb_reg;
        if (gen_cmd) begin
            ctrl_next = REG_RESET;
        end
        if (clr) begin
            txm_next = REG_RESET;
            rxm_next = REG_RESET; // RULE6
            tx_full_next = 1'b0;
            rx_rdy_next = 1'b0;
        end
        // Read view frozen while a bus frame is open
        view_next = view_reg;
        if (cs_s2) begin
            view_next.rx_byte = rxb_reg;
            view_next.status = 16'h0000;
            view_next.status[ST_TX_READY_BIT] = !tx_full_reg && !clr;
            view_next.status[ST_RX_READY_BIT] = rx_rdy_reg;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_reg <= REG_RESET;
            txm_reg <= REG_RESET;
            rxm_reg <= REG_RESET;
            txb_reg <= 8'h00;
            rxb_reg <= 8'h00;
            tx_full_reg <= 1'b0;
            rx_rdy_reg <= 1'b0;
            view_reg <= '0;
        end else begin
            ctrl_reg <= ctrl_next;
            txm_reg <= txm_next;
            rxm_reg <= rxm_next;
            txb_reg <= txb_next;
            rxb_reg <= rxb_next;
            tx_full_reg <= tx_full_next;
            rx_rdy_reg <= rx_rdy_next;
            view_reg <= view_next;
        end
    end

    // Tone selection and receive setting decode
    always_comb begin
        tone_next = '0;
        if (txm_reg[15:MODE_LSB] == MODE_TONES) begin
            if (txm_reg[TONE_TYPE_BIT]) begin
                tone_next.low_hz = DTMF_LOW_HZ[txm_reg[3:0]]; // RULE4
                tone_next.high_hz = DTMF_HIGH_HZ[txm_reg[3:0]]; // RULE4
            end else if (txm_reg[3:2] == 2'b11) begin
                tone_next.pair = 3'(txm_reg[3:0] - PAIR_BASE); // RULE3
            end else begin
                tone_next.low_hz = TONE_HZ[txm_reg[3:0]]; // RULE2
            end
        end
        atten_next = 7'(GAIN_TOP_CODE - rxm_reg[11:LEVEL_LSB])
            * GAIN_STEP_TENTH_DB; // RULE7
    end

    // Receive settings
    always_comb begin
        rx_on = rxm_reg[15:MODE_LSB] != MODE_OFF
            && rxm_reg[15:MODE_LSB] != MODE_TONES
            && rxm_reg[5:USART_LSB] inside {USART_SYNC, USART_ASYNC}; // RULE8
        rsync = rxm_reg[5:USART_LSB] == USART_SYNC; // RULE8
        rnd = rsync ? BYTE_BITS
            : CHAR_MIN_BITS + {2'b00, rxm_reg[2:1]}; // RULE9 RULE10
        rtot = rnd + {3'b000, rxm_reg[0] && !rsync}; // RULE9
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_tone <= '0;
            tx_mode <= 4'h0;
            rx_mode <= 4'h0;
            rx_atten_tenth_db <= 7'h00;
            rx_usart_on <= 1'b0;
            rx_sync <= 1'b0;
            rx_char_bits <= 4'h0;
            rx_parity_en <= 1'b0;
            rx_detector <= 3'h0;
        end else begin
            tx_tone <= tone_next;
            tx_mode <= txm_reg[15:MODE_LSB];
            rx_mode <= rxm_reg[15:MODE_LSB]; // RULE5
            rx_atten_tenth_db <= atten_next;
            rx_usart_on <= rx_on;
            rx_sync <= rx_on && rsync;
            rx_char_bits <= rx_on ? rnd : 4'h0;
            rx_parity_en <= rx_on && !rsync && rxm_reg[0];
            rx_detector <= (rxm_reg[15:MODE_LSB] == MODE_TONES)
                ? rxm_reg[2:0] : 3'h0; // RULE12
        end
    end

    // Transmit framing and serialiser
    always_comb begin
        tmodem = txm_reg[15:MODE_LSB] != MODE_OFF
            && txm_reg[15:MODE_LSB] != MODE_TONES;
        tsync = txm_reg[4:3] == TX_FMT_SYNC;
        nd = CHAR_MIN_BITS + {2'b00, txm_reg[2:1]};
        par = 1'b0;
        frame = 12'hfff;
        if (tsync) begin
            frame[7:0] = txb_reg; // RULE14
            flen = BYTE_BITS;
        end else begin
            frame[0] = 1'b0; // RULE15
            for (int i = 0; i < 8; i++) begin
                if (4'(i) < nd) begin
                    frame[i + 1] = txb_reg[i]; // RULE15
                    par = par ^ txb_reg[i];
                end
            end
            if (txm_reg[4:3] != TX_FMT_NOPAR) begin
                frame[nd + 4'h1] = (txm_reg[4:3] == TX_FMT_EVEN) ? par : !par;
            end
            flen = nd + 4'h2 + {3'b000, txm_reg[4:3] != TX_FMT_NOPAR}
                + {3'b000, txm_reg[0]}; // RULE15
        end
        ttick_next = (ttick_reg == BIT_LAST) ? CW'(0) : ttick_reg + CW'(1);
        tsh_next = tsh_reg;
        tcnt_next = tcnt_reg;
        tline_next = tx_line_bit;
        if (ttick_reg == CW'(0)) begin
            if (tcnt_reg != 4'h0) begin
                tline_next = tsh_reg[0];
                tsh_next = {1'b1, tsh_reg[11:1]};
                tcnt_next = tcnt_reg - 4'h1;
            end else if (tmodem && tx_full_reg) begin
                tline_next = frame[0];
                tsh_next = {1'b1, frame[11:1]};
                tcnt_next = flen - 4'h1;
            end else begin
                tline_next = 1'b1;
            end
        end
        if (clr) begin
            tcnt_next = 4'h0;
            tline_next = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ttick_reg <= '0;
            tsh_reg <= 12'hfff;
            tcnt_reg <= 4'h0;
            tx_line_bit <= 1'b1;
        end else begin
            ttick_reg <= ttick_next;
            tsh_reg <= tsh_next;
            tcnt_reg <= tcnt_next;
            tx_line_bit <= tline_next;
        end
    end

    // Receive deserialiser, mid-bit sampling
    always_comb begin
        rst_next = rst_reg;
        rtim_next = (rtim_reg == CW'(0)) ? BIT_LAST : rtim_reg - CW'(1);
        ridx_next = ridx_reg;
        rsh_next = rsh_reg;
        rx_done = 1'b0;
        unique case (rst_reg)
            RX_IDLE: begin
                rsh_next = 8'h00;
                ridx_next = 4'h0;
                rtim_next = BIT_HALF;
                if (rx_on && rsync) begin
                    rst_next = RX_DATA;
                end else if (rx_on && !line_s2) begin
                    rst_next = RX_START;
                end
            end
            RX_START: begin
                if (rtim_reg == CW'(0)) begin
                    rst_next = line_s2 ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (rtim_reg == CW'(0)) begin
                    if (ridx_reg < rnd) begin
                        rsh_next[ridx_reg[2:0]] = line_s2; // RULE17 RULE18
                    end
                    ridx_next = ridx_reg + 4'h1;
                    if (ridx_reg == rtot - 4'h1) begin
                        rx_done = 1'b1;
                        ridx_next = 4'h0;
                        rst_next = rsync ? RX_DATA : RX_IDLE;
                    end
                end
            end
        endcase
        if (!rx_on || clr) begin
            rst_next = RX_IDLE;
            rx_done = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rst_reg <= RX_IDLE;
            rtim_reg <= '0;
            ridx_reg <= 4'h0;
            rsh_reg <= 8'h00;
        end else begin
            rst_reg <= rst_next;
            rtim_reg <= rtim_next;
            ridx_reg <= ridx_next;
            rsh_reg <= (rx_done && rsync) ? 8'h00 : rsh_next;
        end
    end

    property p_mode_clear;
        @(posedge clk) disable iff (sys_rst)
        clr |=> rxm_reg == REG_RESET && txm_reg == REG_RESET;
    endproperty
    a_mode_clear: assert property (p_mode_clear) // RULE6
        else $error("mode registers not cleared");

    property p_no_tone;
        @(posedge clk) disable iff (sys_rst)
        txm_reg[15:MODE_LSB] == MODE_TONES && txm_reg[4:0] == 5'h00
        |=> tx_tone.low_hz == 12'd0 && tx_tone.high_hz == 12'd0;
    endproperty
    a_no_tone: assert property (p_no_tone) // RULE2
        else $error("code zero produced a tone");

    property p_pair;
        @(posedge clk) disable iff (sys_rst)
        txm_reg[15:MODE_LSB] == MODE_TONES && txm_reg[4:2] == 3'b011
        |=> tx_tone.pair == {1'b1, $past(txm_reg[1:0])} - 3'h3;
    endproperty
    a_pair: assert property (p_pair) // RULE3
        else $error("wrong programmed pair");

    property p_dtmf;
        @(posedge clk) disable iff (sys_rst)
        txm_reg[15:MODE_LSB] == MODE_TONES && txm_reg[4:0] == 5'h10
        |=> tx_tone.low_hz == 12'd941 && tx_tone.high_hz == 12'd1633;
    endproperty
    a_dtmf: assert property (p_dtmf) // RULE4
        else $error("keypad D tones wrong");

    property p_gain;
        @(posedge clk) disable iff (sys_rst)
        rxm_reg[11:LEVEL_LSB] == 3'h0 ##1 rxm_reg[11:LEVEL_LSB] == 3'h0
        |-> rx_atten_tenth_db == 7'd105;
    endproperty
    a_gain: assert property (p_gain) // RULE7
        else $error("lowest gain not -10.5 dB");

    property p_sync_len;
        @(posedge clk) disable iff (sys_rst)
        rx_sync |-> rx_char_bits == BYTE_BITS;
    endproperty
    a_sync_len: assert property (p_sync_len) // RULE10
        else $error("sync receive length not eight");

    property p_tx_ready;
        @(posedge clk) disable iff (sys_rst)
        wr_evt && wr.addr == ADDR_TX_BYTE && !clr |=> tx_full_reg;
    endproperty
    a_tx_ready: assert property (p_tx_ready) // RULE19
        else $error("data write left ready set");

    property p_rx_ready;
        @(posedge clk) disable iff (sys_rst)
        rx_done |=> rx_rdy_reg && rxb_reg == $past(rsh_next);
    endproperty
    a_rx_ready: assert property (p_rx_ready) // RULE20
        else $error("received byte not flagged");
endmodule

// *** mtm_pkg.sv ***
// Constants, types and register map of the modem mode and data registers
//Function
//RULE1 - Host zeroes twist bits in tone mode
//RULE2 - Tone codes pick fixed single tones
//RULE3 - Codes 1100-1111 pick programmed pairs A-D
//RULE4 - Tone-type one picks keypad dual tones
//RULE5 - Receive mode field selects receiver type
//RULE6 - Receive mode cleared by reset conditions
//RULE7 - Receive gain 0 to -10.5 dB steps
//RULE8 - USART bits select sync, start-stop, off
//RULE9 - Start-stop character length and parity bit
//RULE10 - Sync receive ignores character format bits
//RULE11 - Host zeroes bits 8-3 in tones detect
//RULE12 - Detector type chosen in tones detect
//RULE13 - No call progress while line disconnected
//RULE14 - Sync transmit sends bytes LSB first
//RULE15 - Start-stop transmit adds start, parity, stops
//RULE16 - Host writes data only when ready
//RULE17 - Sync receive byte earliest bit at b0
//RULE18 - Start-stop receive bits low, zeros above
//RULE19 - Tx ready flag cleared by data write
//RULE20 - Rx ready flag cleared by data read
package mtm_pkg;
    // Bus addresses
    localparam logic [7:0] ADDR_GEN_RESET = 8'h01;
    localparam logic [7:0] ADDR_GEN_CTRL = 8'he0;
    localparam logic [7:0] ADDR_TX_MODE = 8'he1;
    localparam logic [7:0] ADDR_RX_MODE = 8'he2;
    localparam logic [7:0] ADDR_TX_BYTE = 8'he3;
    localparam logic [7:0] ADDR_RX_BYTE = 8'he5;
    localparam logic [7:0] ADDR_STATUS = 8'he6;
    localparam logic [4:0] ADDR_BITS = 5'h08;
    // Field positions
    localparam int MODE_LSB = 12;
    localparam int LEVEL_LSB = 9;
    localparam int USART_LSB = 3;
    localparam int TONE_TYPE_BIT = 4;
    localparam int CTRL_RESET_BIT = 7;
    localparam int ST_TX_READY_BIT = 12;
    localparam int ST_RX_READY_BIT = 6;
    localparam logic [15:0] REG_RESET = 16'h0000;
    // Mode encodings
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_TONES = 4'h1;
    localparam logic [2:0] USART_SYNC = 3'h7;
    localparam logic [2:0] USART_ASYNC = 3'h6;
    localparam logic [1:0] TX_FMT_SYNC = 2'h3;
    localparam logic [1:0] TX_FMT_NOPAR = 2'h2;
    localparam logic [1:0] TX_FMT_EVEN = 2'h1;
    localparam logic [3:0] PAIR_BASE = 4'hb;
    localparam logic [3:0] CHAR_MIN_BITS = 4'h5;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [2:0] GAIN_TOP_CODE = 3'h7;
    localparam logic [6:0] GAIN_STEP_TENTH_DB = 7'h0f;
    // Bit rate timing
    localparam int CLK_HZ = 40000000;
    localparam int BAUD_HZ = 1200;
    // Fixed single tones, indexed by code
    localparam logic [11:0] TONE_HZ [16] = '{12'd0, 12'd697, 12'd770,
        12'd852, 12'd941, 12'd1209, 12'd1336, 12'd1477, 12'd1633,
        12'd1300, 12'd2100, 12'd2225, 12'd0, 12'd0, 12'd0, 12'd0};
    // Keypad dual tones, indexed by code
    localparam logic [11:0] DTMF_LOW_HZ [16] = '{12'd941, 12'd697,
        12'd697, 12'd697, 12'd770, 12'd770, 12'd770, 12'd852, 12'd852,
        12'd852, 12'd941, 12'd941, 12'd941, 12'd697, 12'd770, 12'd852};
    localparam logic [11:0] DTMF_HIGH_HZ [16] = '{12'd1633, 12'd1209,
        12'd1336, 12'd1477, 12'd1209, 12'd1336, 12'd1477, 12'd1209,
        12'd1336, 12'd1477, 12'd1336, 12'd1209, 12'd1477, 12'd1633,
        12'd1633, 12'd1633};

    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] data;
    } mtm_wr_t;

    typedef struct packed {
        logic [15:0] status;
        logic [7:0] rx_byte;
    } mtm_view_t;

    typedef struct packed {
        logic [11:0] low_hz;
        logic [11:0] high_hz;
        logic [2:0] pair;
    } mtm_tone_t;

    // Payload length after the address byte
    function automatic logic [4:0] mtm_len(input logic [7:0] a);
        unique case (a)
            ADDR_GEN_CTRL, ADDR_TX_MODE, ADDR_RX_MODE, ADDR_STATUS:
                mtm_len = 5'h10;
            ADDR_TX_BYTE, ADDR_RX_BYTE: mtm_len = 5'h08;
            default: mtm_len = 5'h00;
        endcase
    endfunction

    function automatic logic mtm_is_read(input logic [7:0] a);
        mtm_is_read = (a == ADDR_RX_BYTE) || (a == ADDR_STATUS);
    endfunction
endpackage

// *** mtm_serial_slave.sv ***
// Serial control bus slave running on the bus clock
`timescale 1ns/1ps
module mtm_serial_slave import mtm_pkg::*; (
    input wire logic sys_rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic cmd_in,
    input wire mtm_view_t view,
    output logic reply_out,
    output logic reply_oe,
    output mtm_wr_t wr,
    output logic wr_tgl,
    output logic rd_tgl
);
    logic [4:0] cnt_reg, cnt_next;
    logic [7:0] addr_reg, addr_next;
    logic [15:0] sh_reg, sh_next;
    logic [15:0] rsh_reg, rsh_next;
    logic oe_next;
    logic wr_evt, rd_evt;
    logic [7:0] addr_now;
    mtm_wr_t wr_next;

    // Frame decode on rising bus clock
    always_comb begin
        addr_now = {addr_reg[6:0], cmd_in};
        cnt_next = (cnt_reg == 5'h1f) ? cnt_reg : cnt_reg + 5'h01;
        addr_next = (cnt_reg < ADDR_BITS) ? addr_now : addr_reg;
        sh_next = {sh_reg[14:0], cmd_in};
        wr_next = wr;
        wr_evt = 1'b0;
        if (cnt_reg == ADDR_BITS - 5'h01 && addr_now == ADDR_GEN_RESET) begin
            wr_evt = 1'b1;
            wr_next = '{addr: ADDR_GEN_RESET, data: REG_RESET};
        end else if (cnt_reg >= ADDR_BITS && !mtm_is_read(addr_reg)
                     && mtm_len(addr_reg) != 5'h00
                     && cnt_reg == ADDR_BITS + mtm_len(addr_reg) - 5'h01) begin
            wr_evt = 1'b1;
            wr_next = '{addr: addr_reg, data: sh_next};
        end
    end

    // Frame state, cleared whenever select is high
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            cnt_reg <= 5'h00;
            addr_reg <= 8'h00;
            sh_reg <= 16'h0000;
        end else begin
            cnt_reg <= cnt_next;
            addr_reg <= addr_next;
            sh_reg <= sh_next;
        end
    end

    // Completed writes handed over by toggle
    always_ff @(posedge sclk or posedge sys_rst) begin
        if (sys_rst) begin
            wr <= '0;
            wr_tgl <= 1'b0;
        end else begin
            wr <= wr_next;
            wr_tgl <= wr_tgl ^ wr_evt;
        end
    end

    // Reply shifter, loaded after the address byte
    always_comb begin
        rd_evt = 1'b0;
        oe_next = reply_oe;
        rsh_next = {rsh_reg[14:0], 1'b0};
        if (cnt_reg == ADDR_BITS) begin
            oe_next = mtm_is_read(addr_reg);
            rd_evt = (addr_reg == ADDR_RX_BYTE);
            rsh_next = (addr_reg == ADDR_STATUS) ? view.status
                : {view.rx_byte, 8'h00};
        end
    end

    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            rsh_reg <= 16'h0000;
            reply_out <= 1'b0;
            reply_oe <= 1'b0;
        end else begin
            rsh_reg <= rsh_next;
            reply_out <= rsh_next[15];
            reply_oe <= oe_next;
        end
    end

    // Receive data reads handed over by toggle
    always_ff @(negedge sclk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_tgl <= 1'b0;
        end else begin
            rd_tgl <= rd_tgl ^ rd_evt;
        end
    end
endmodule

// *** mtm_host_model.sv ***
// Host controller model driving the serial control bus
`timescale 1ns/1ps
module mtm_host_model (
    output logic sclk,
    output logic cs_n,
    output logic cmd,
    input wire logic reply,
    input wire logic reply_oe
);
    // Bus clock stands high and still outside frames
    initial begin
        sclk = 1'b1;
        cmd = 1'b0;
        cs_n = 1'b0;
        #1;
        cs_n = 1'b1; // Rising select clears the frame logic
    end

    // One frame: address then n payload bits, MSB first
    task automatic xfer(input logic [7:0] a, input logic [15:0] d,
        input int n, output logic [15:0] q);
        logic [23:0] sh;
        sh = {a, 16'(d << (16 - n))};
        q = 16'h0000;
        cs_n = 1'b0;
        #15;
        for (int i = 0; i < 8 + n; i++) begin
            sclk = 1'b0;
            cmd = sh[23];
            sh = sh << 1;
            #15;
            sclk = 1'b1;
            if (i >= 8) q = {q[14:0], reply_oe ? reply : 1'bx};
            #15;
        end
        cmd = ~cmd; // Released line shows no stale value
        #15;
        cs_n = 1'b1;
        #200;
    endtask
endmodule

// *** tb_mtm_regs.sv ***
// Self-checking bench of the mode and data registers
`timescale 1ns/1ps
module tb_mtm_regs;
    import mtm_pkg::*;
    localparam int BC = 32;
    logic clk = 1'b0;
    logic sys_rst = 1'b0;
    logic rx_bit = 1'b1;
    logic sclk, cs_n, cmd, reply, reply_oe, tx_bit, on, sync, par;
    mtm_tone_t tone;
    logic [3:0] txm, rxm, cbits;
    logic [6:0] att;
    logic [2:0] det;
    int errors = 0;
    int tests_run = 0;
    logic [31:0] seed = 32'he89570ab;
    logic [15:0] q, v;
    logic [20:0] e;
    logic [9:0] f1, f2;
    logic [7:0] d1, d2, m;
    logic [4:0] sv;

    always #12.5 clk = ~clk;

    mtm_host_model mtm_host_model_inst (.sclk(sclk), .cs_n(cs_n),
        .cmd(cmd), .reply(reply), .reply_oe(reply_oe));
    mtm_regs #(.BIT_CYCLES(BC)) mtm_regs_inst (.clk(clk),
        .sys_rst(sys_rst), .bus_sclk(sclk), .bus_cs_n(cs_n),
        .bus_cmd_in(cmd), .bus_reply_out(reply), .bus_reply_oe(reply_oe),
        .rx_line_bit(rx_bit), .tx_line_bit(tx_bit), .tx_tone(tone),
        .tx_mode(txm), .rx_mode(rxm), .rx_atten_tenth_db(att),
        .rx_usart_on(on), .rx_sync(sync), .rx_char_bits(cbits),
        .rx_parity_en(par), .rx_detector(det));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Expected {mode, atten, on, sync, bits, parity, detector}
    function automatic logic [20:0] rx_exp(input logic [15:0] w);
        logic o, s;
        o = w[15:12] > 4'h1 && w[5:4] == 2'b11;
        s = o && w[3];
        return {w[15:12], 7'((7 - w[11:9]) * 15), o, s,
            (o && !s) ? 4'(5 + w[2:1]) : 4'h0, o && !s && w[0],
            w[15:12] == 4'h1 ? w[2:0] : 3'h0};
    endfunction

    task automatic chk(input logic ok, input string s);
        tests_run++;
        if (ok !== 1'b1) begin
            errors++;
            $display("BAD %0t %s", $time, s);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d, int n);
        mtm_host_model_inst.xfer(a, d, n, q);
        repeat (8) @(posedge clk);
        #2;
    endtask

    // Sample one transmitted character mid-bit
    task automatic cap(output logic [9:0] f);
        int k = 0;
        while (tx_bit !== 1'b0 && k < 4000) begin
            @(posedge clk);
            k++;
        end
        repeat (BC / 2) @(posedge clk);
        for (int j = 0; j < 10; j++) begin
            f[j] = tx_bit;
            if (j < 9) repeat (BC) @(posedge clk);
        end
    endtask

    task automatic send(input logic [9:0] f);
        for (int j = 0; j < 10; j++) begin
            rx_bit = f[j];
            repeat (BC) @(posedge clk);
            #2;
        end
    endtask

    task automatic stop_test;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #500us;
        errors++;
        stop_test;
    end

    initial begin
        #1 sys_rst = 1'b1; // Real edge for the async resets
        repeat (8) @(posedge clk);
        #2 sys_rst = 1'b0;
        chk(tx_bit === 1'b1 && rxm === 4'h0 && det === 3'h0, "reset");
        repeat (4) @(posedge clk);
        // Every tone code, twist left at zero
        for (int i = 0; i < 32; i++) begin
            wr(ADDR_TX_MODE, 16'h1000 | 16'(i), 16);
            if (i[4]) chk(tone === {DTMF_LOW_HZ[i % 16],
                DTMF_HIGH_HZ[i % 16], 3'h0}, "dtmf");
            else if (i < 12) chk(tone === {TONE_HZ[i], 12'd0, 3'h0},
                "tone");
            else chk(tone.pair === 3'(i - 11), "pair");
        end
        // Random receive modes, first two synchronous
        for (int i = 0; i < 40; i++) begin
            v = 16'(rnd());
            v[15:12] = 4'(v[15:12] % 10);
            if (v[15:12] == 4'h1) v[8:3] = 6'h00;
            if (v[15:12] == 4'h1 && v[2:0] == 3'h3) v[0] = 1'b0;
            if (v[5:4] == 2'b10) v[5] = 1'b0;
            if (i < 2) v = 16'h3e38 | 16'(i * 7);
            e = rx_exp(v);
            wr(ADDR_RX_MODE, v, 16);
            chk({rxm, att, on, sync, det} === {e[20:8], e[2:0]},
                "rx mode");
            if (!e[8]) chk({cbits, par} === e[7:3], "format");
            if (i == 1) chk({cbits, par} === sv, "sync format");
            sv = {cbits, par};
        end
        // Control reset bit held, then general reset
        wr(ADDR_GEN_CTRL, 16'h0080, 16);
        wr(ADDR_RX_MODE, 16'h3e36, 16);
        chk(rxm === 4'h0 && on === 1'b0 && txm === 4'h0, "held");
        wr(ADDR_GEN_CTRL, 16'h0000, 16);
        wr(ADDR_RX_MODE, 16'h3e36, 16);
        chk(rxm === 4'h3, "rx mode");
        wr(ADDR_GEN_RESET, 16'h0000, 0);
        chk(rxm === 4'h0 && cbits === 4'h0, "gen reset");
        // Two back-to-back start-stop characters, 8 data 1 stop
        d1 = 8'(rnd());
        d2 = 8'(rnd());
        wr(ADDR_TX_MODE, 16'h2016, 16);
        fork
            cap(f1);
            begin
                mtm_host_model_inst.xfer(ADDR_STATUS, 16'h0, 16, q);
                chk(q[ST_TX_READY_BIT] === 1'b1, "tx ready");
                wr(ADDR_TX_BYTE, {8'h00, d1}, 8);
                for (int k = 0; k < 20 && q[ST_TX_READY_BIT] !== 1'b1; k++)
                    mtm_host_model_inst.xfer(ADDR_STATUS, 16'h0, 16, q);
                wr(ADDR_TX_BYTE, {8'h00, d2}, 8);
                mtm_host_model_inst.xfer(ADDR_STATUS, 16'h0, 16, q);
                chk(q[ST_TX_READY_BIT] === 1'b0, "tx full");
            end
        join
        cap(f2);
        chk(f1 === {1'b1, d1, 1'b0} && f2 === {1'b1, d2, 1'b0},
            "tx");
        // Receive 8-bit and 5-bit characters
        for (int n = 8; n >= 5; n -= 3) begin
            d1 = 8'(rnd());
            m = 8'hff >> (8 - n);
            wr(ADDR_RX_MODE, {4'h3, 3'h7, 3'h0, 3'h6,
                n == 8 ? 3'h6 : 3'h0}, 16);
            send({1'b1, d1 | ~m, 1'b0});
            q = 16'h0000;
            for (int k = 0; k < 20 && q[ST_RX_READY_BIT] !== 1'b1; k++)
                mtm_host_model_inst.xfer(ADDR_STATUS, 16'h0, 16, q);
            chk(q[ST_RX_READY_BIT] === 1'b1, "rx ready");
            wr(ADDR_RX_BYTE, 16'h0, 8);
            chk(q[7:0] === (d1 & m), "rx byte");
            mtm_host_model_inst.xfer(ADDR_STATUS, 16'h0, 16, q);
            chk(q[ST_RX_READY_BIT] === 1'b0, "rx clear");
        end
        // Synchronous byte, LSB first, idle ones after
        d1 = 8'(rnd()) & 8'hfe;
        wr(ADDR_TX_MODE, 16'h2018, 16);
        fork
            cap(f1);
            wr(ADDR_TX_BYTE, {8'h00, d1}, 8);
        join
        chk(f1 === {2'b11, d1}, "tx sync");
        stop_test;
    end
endmodule
